//--- hdl/dcm_ctrl.sv
// control word decode and monitor multiplexer select
`timescale 1ns/100ps
`default_nettype none
module dcm_ctrl #(
    parameter bit REF_LEVEL_DEFAULT = 1'b1
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // command in
    input wire logic CMD_VALID_I,
    input wire dcm_pkg::dcm_cmd_t CMD_I,
    input wire logic LOAD_OUTPUTS_STROBE_I,
    input wire logic OVER_TEMP_I,
    // readback
    output logic [11:0] RD_DATA_O,
    output logic RD_VALID_O,
    // control outputs
    output logic PD_HIGHZ_O,
    output logic REF_LEVEL_HIGH_O,
    output logic AMP_BOOST_O,
    output logic INT_REF_EN_O,
    output logic AMPS_POWERED_O,
    output logic [31:0] TOGGLE_SEL_B_O,
    // monitor
    output logic [5:0] MON_SEL_O,
    output logic MONITOR_OUTPUT_EN_O,
    output logic MON_EXT_O
);
    import dcm_pkg::*;
    logic [11:0] ctrl_r;
    logic [5:0] mon_sel_r;
    logic powered_r;
    logic [31:0] toggle_r;
    logic special;
    logic is_ctrl_wr;
    logic is_ctrl_rd;
    logic is_mon_wr;
    logic is_pup;
    logic is_pdn;
    logic [5:0] mon_nxt;
    logic mon_en_nxt;

    assign special = CMD_VALID_I && (CMD_I.target_sel == TGT_SPECIAL);
    assign is_ctrl_wr = special && CMD_I.cmd_addr == CMD_CTRL && !CMD_I.rw;
    assign is_ctrl_rd = special && CMD_I.cmd_addr == CMD_CTRL && CMD_I.rw;
    assign is_mon_wr = special && CMD_I.cmd_addr == CMD_MON && !CMD_I.rw;
    assign is_pup = special && CMD_I.cmd_addr == CMD_PUP && !CMD_I.rw;
    assign is_pdn = special && CMD_I.cmd_addr == CMD_PDN && !CMD_I.rw;

    // control word; spare bits are stored but drive nothing
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ctrl_r <= CTRL_RESET;
            ctrl_r[BIT_REFLVL] <= REF_LEVEL_DEFAULT;
        end else if (is_ctrl_wr) begin
            ctrl_r <= CMD_I.data;
        end
    end

    // readback leaves all settings unchanged
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            RD_DATA_O <= 12'h0000;
            RD_VALID_O <= 1'b0;
        end else begin
            RD_VALID_O <= is_ctrl_rd;
            if (is_ctrl_rd) begin
                RD_DATA_O <= ctrl_r;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            PD_HIGHZ_O <= 1'b1;
            REF_LEVEL_HIGH_O <= REF_LEVEL_DEFAULT;
            AMP_BOOST_O <= 1'b0;
            INT_REF_EN_O <= 1'b0;
        end else begin
            PD_HIGHZ_O <= ctrl_r[BIT_PDMODE];
            REF_LEVEL_HIGH_O <= ctrl_r[BIT_REFLVL];
            AMP_BOOST_O <= ctrl_r[BIT_BOOST];
            INT_REF_EN_O <= ctrl_r[BIT_REFEN];
        end
    end

    // amplifier power: thermal trip wins, power-up only when cool or thermal guard clear
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            powered_r <= 1'b0;
        end else if (ctrl_r[BIT_THERM] && OVER_TEMP_I) begin
            powered_r <= 1'b0;
        end else if (is_pup) begin
            powered_r <= 1'b1;
        end else if (is_pdn) begin
            powered_r <= 1'b0;
        end
    end
    assign AMPS_POWERED_O = powered_r;

    // per-channel A/B selection flips on each load strobe while its group's toggle bit is set; held at 0 while clear
    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_tog
            always_ff @(posedge CLK_I) begin
                if (RST_I) begin
                    toggle_r[g] <= 1'b0;
                end else if (!ctrl_r[g / 8]) begin
                    toggle_r[g] <= 1'b0;
                end else if (LOAD_OUTPUTS_STROBE_I) begin
                    toggle_r[g] <= !toggle_r[g];
                end
            end
        end
    endgenerate
    assign TOGGLE_SEL_B_O = toggle_r;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            mon_sel_r <= MON_TRISTATE;
        end else if (is_mon_wr) begin
            mon_sel_r <= CMD_I.data[11:MON_LSB];
        end
    end

    always_comb begin
        mon_nxt = mon_sel_r;
        mon_en_nxt = ctrl_r[BIT_MONEN] && mon_sel_r != MON_TRISTATE;
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            MON_SEL_O <= MON_TRISTATE;
            MONITOR_OUTPUT_EN_O <= 1'b0;
            MON_EXT_O <= 1'b0;
        end else begin
            MON_SEL_O <= mon_nxt;
            MONITOR_OUTPUT_EN_O <= mon_en_nxt;
            MON_EXT_O <= mon_nxt >= MON_EXT_BASE && mon_nxt <= MON_EXT_LAST;
        end
    end

    // assertions share the one clock; reset masks them
    default clocking dcm_cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    // a write followed by a quiet cycle: decoded copies have caught up
    sequence s_wr_settled;
        is_ctrl_wr ##1 !is_ctrl_wr;
    endsequence

    // monitor command, then the cycle in which the select register holds it
    sequence s_mon_cmd;
        is_mon_wr ##1 1'b1;
    endsequence

    sequence s_trip;
        ctrl_r[BIT_THERM] && OVER_TEMP_I;
    endsequence

    sequence s_cool_pup;
        is_pup && !(ctrl_r[BIT_THERM] && OVER_TEMP_I);
    endsequence

    // power-up asked for while the die is still hot
    sequence s_hot_pup;
        is_pup && ctrl_r[BIT_THERM] && OVER_TEMP_I;
    endsequence

    // control word storage and readback
    a_ctrl_write: assert property (
        is_ctrl_wr |=> ctrl_r == $past(CMD_I.data))
        else $error("control write not stored");

    a_ctrl_hold: assert property (
        !is_ctrl_wr |=> $stable(ctrl_r))
        else $error("control changed without write");

    a_spare_kept: assert property (
        is_ctrl_wr |=> ctrl_r[5:4] == $past(CMD_I.data[5:4]))
        else $error("spare bits not stored");

    a_read_back: assert property (
        is_ctrl_rd |=> RD_VALID_O && RD_DATA_O == $past(ctrl_r))
        else $error("readback mismatch");

    a_read_stable: assert property (
        is_ctrl_rd |=> $stable(ctrl_r))
        else $error("read changed control");

    a_rd_pulse: assert property (
        !is_ctrl_rd |=> !RD_VALID_O)
        else $error("read valid without read");

    a_rd_hold: assert property (
        !is_ctrl_rd |=> $stable(RD_DATA_O))
        else $error("read data changed without read");

    // command decode
    a_special_only: assert property (
        CMD_VALID_I && CMD_I.target_sel != TGT_SPECIAL
        |=> $stable(ctrl_r) && $stable(mon_sel_r))
        else $error("non-special command acted");

    a_rw_ignored: assert property (
        special && CMD_I.rw && CMD_I.cmd_addr != CMD_CTRL
        |=> $stable(ctrl_r) && $stable(mon_sel_r))
        else $error("read of write-only command acted");

    a_idle_stable: assert property (
        !CMD_VALID_I |=> $stable(ctrl_r) && $stable(mon_sel_r))
        else $error("state changed while idle");

    // decoded control outputs
    a_pd_mode: assert property (
        s_wr_settled |=> PD_HIGHZ_O == ctrl_r[BIT_PDMODE])
        else $error("power-down mode wrong");

    a_ref_level: assert property (
        s_wr_settled |=> REF_LEVEL_HIGH_O == ctrl_r[BIT_REFLVL])
        else $error("reference level wrong");

    a_amp_boost: assert property (
        s_wr_settled |=> AMP_BOOST_O == ctrl_r[BIT_BOOST])
        else $error("boost wrong");

    a_ref_enable: assert property (
        s_wr_settled |=> INT_REF_EN_O == ctrl_r[BIT_REFEN])
        else $error("reference enable wrong");

    a_pd_follow: assert property (
        1'b1 |=> PD_HIGHZ_O == $past(ctrl_r[BIT_PDMODE]))
        else $error("power-down mode lags");

    a_ref_follow: assert property (
        1'b1 |=> REF_LEVEL_HIGH_O == $past(ctrl_r[BIT_REFLVL]))
        else $error("reference level lags");

    a_boost_follow: assert property (
        1'b1 |=> AMP_BOOST_O == $past(ctrl_r[BIT_BOOST]))
        else $error("boost lags");

    a_refen_follow: assert property (
        1'b1 |=> INT_REF_EN_O == $past(ctrl_r[BIT_REFEN]))
        else $error("reference enable lags");

    // amplifier power
    a_thermal_trip: assert property (
        s_trip |=> !AMPS_POWERED_O)
        else $error("thermal trip missed");

    a_pup_cool: assert property (
        s_cool_pup |=> AMPS_POWERED_O)
        else $error("power-up failed");

    a_trip_retry: assert property (
        s_trip ##1 s_hot_pup |=> !AMPS_POWERED_O)
        else $error("power-up while hot");

    a_pdn_cmd: assert property (
        is_pdn |=> !AMPS_POWERED_O)
        else $error("power-down ignored");

    a_amps_hold: assert property (
        !is_pup && !is_pdn && !(ctrl_r[BIT_THERM] && OVER_TEMP_I)
        |=> $stable(AMPS_POWERED_O))
        else $error("power changed without cause");

    a_amps_rise: assert property (
        $rose(AMPS_POWERED_O) |-> $past(is_pup))
        else $error("power-up without command");

    // monitor select
    a_mon_tristate: assert property (
        mon_sel_r == MON_TRISTATE |=> !MONITOR_OUTPUT_EN_O)
        else $error("monitor not tristated");

    a_mon_disable: assert property (
        !ctrl_r[BIT_MONEN] |=> !MONITOR_OUTPUT_EN_O)
        else $error("monitor driven while disabled");

    a_mon_enable: assert property (
        ctrl_r[BIT_MONEN] && mon_sel_r != MON_TRISTATE |=> MONITOR_OUTPUT_EN_O)
        else $error("monitor not driven");

    a_mon_select: assert property (
        is_mon_wr |=> mon_sel_r == $past(CMD_I.data[11:MON_LSB]))
        else $error("monitor select wrong");

    a_mon_hold: assert property (
        !is_mon_wr |=> $stable(mon_sel_r))
        else $error("monitor select changed");

    a_mon_follow: assert property (
        1'b1 |=> MON_SEL_O == $past(mon_sel_r))
        else $error("monitor output lags");

    a_mon_route: assert property (
        s_mon_cmd |=> MON_SEL_O == $past(CMD_I.data[11:MON_LSB], 2))
        else $error("monitor route wrong");

    a_mon_ext: assert property (
        mon_sel_r inside {[MON_EXT_BASE:MON_EXT_LAST]} |=> MON_EXT_O)
        else $error("external input not flagged");

    a_mon_chan: assert property (
        !(mon_sel_r inside {[MON_EXT_BASE:MON_EXT_LAST]}) |=> !MON_EXT_O)
        else $error("external flag on channel");

    // toggle groups
    a_toggle_flip: assert property (
        ctrl_r[0] && LOAD_OUTPUTS_STROBE_I
        |=> toggle_r[0] != $past(toggle_r[0]))
        else $error("toggle did not flip");

    a_flip_group3: assert property (
        ctrl_r[3] && LOAD_OUTPUTS_STROBE_I
        |=> TOGGLE_SEL_B_O[31] != $past(TOGGLE_SEL_B_O[31]))
        else $error("group three did not flip");

    a_toggle_hold: assert property (
        ctrl_r[0] && !LOAD_OUTPUTS_STROBE_I
        |=> $stable(TOGGLE_SEL_B_O[7:0]))
        else $error("group zero flipped without strobe");

    a_hold_group3: assert property (
        ctrl_r[3] && !LOAD_OUTPUTS_STROBE_I
        |=> $stable(TOGGLE_SEL_B_O[31:24]))
        else $error("group three flipped without strobe");

    a_group0_off: assert property (
        !ctrl_r[0] |=> TOGGLE_SEL_B_O[7:0] == 8'h00)
        else $error("group zero toggles while off");

    a_group1_off: assert property (
        !ctrl_r[1] |=> TOGGLE_SEL_B_O[15:8] == 8'h00)
        else $error("group one toggles while off");

    a_group2_off: assert property (
        !ctrl_r[2] |=> TOGGLE_SEL_B_O[23:16] == 8'h00)
        else $error("group two toggles while off");

    a_group3_off: assert property (
        !ctrl_r[3] |=> TOGGLE_SEL_B_O[31:24] == 8'h00)
        else $error("group three toggles while off");

    a_group_same: assert property (
        1'b1 |-> TOGGLE_SEL_B_O[15:8] == {8{TOGGLE_SEL_B_O[8]}})
        else $error("group channels disagree");
endmodule
`default_nettype wire

//--- hdl/dcm_pkg.sv
// package for the dac control word and monitor select block
// Overview of operation
// - control word sits at target bits 00, command 01100; rw 0 write, 1 read
// - write takes all twelve data bits; read returns them in the same positions
// - power-down mode bit: 1 high impedance, 0 resistive load; resets to 1
// - reference level bit picks high or low internal level; reset per variant
// - boost bit raises amplifier bias when set; resets to 0
// - reference enable bit selects internal reference when set; resets to 0
// - monitor enable lets monitor commands route; clear tristates the monitor
// - thermal guard set and over temperature powers down the amplifiers
// - soft power-up re-enables amplifiers only below the temperature limit while the thermal guard is set; with it clear, also when hot
// - spare bits five and four change no behaviour
// - four toggle bits enable toggle mode per group of eight channels
// - each load strobe swaps toggled channels between their A and B codes
// - monitor command at target 00, command 01010; address from bits 11..6
// - monitor address 63 three-states the monitor output
// - low six bits ignored; 0..31 channels, 32..35 external inputs
// - target bits both zero send the command to the special decoder
// - soft power-up command 01001 powers up the amplifiers; the reference enable is left as is
package dcm_pkg;
    localparam logic [1:0] TGT_SPECIAL = 2'h0;
    localparam logic [4:0] CMD_CTRL = 5'h0C;
    localparam logic [4:0] CMD_MON = 5'h0A;
    localparam logic [4:0] CMD_PDN = 5'h08;
    localparam logic [4:0] CMD_PUP = 5'h09;
    localparam int BIT_PDMODE = 11;
    localparam int BIT_REFLVL = 10;
    localparam int BIT_BOOST = 9;
    localparam int BIT_REFEN = 8;
    localparam int BIT_MONEN = 7;
    localparam int BIT_THERM = 6;
    localparam int MON_LSB = 6;
    localparam logic [11:0] CTRL_RESET = 12'h0800;
    localparam logic [5:0] MON_TRISTATE = 6'h3F;
    localparam logic [5:0] MON_EXT_BASE = 6'h20;
    localparam logic [5:0] MON_EXT_LAST = 6'h23;
    typedef struct packed {
        logic [1:0] target_sel;
        logic rw;
        logic [4:0] cmd_addr;
        logic [11:0] data;
    } dcm_cmd_t;
endpackage

//--- bench/dcm_host.sv
// host model that issues commands to the control block
`timescale 1ns/100ps
`default_nettype none
module dcm_host (
    // clock
    input wire logic clk_i,
    // command out
    output logic valid_o,
    output dcm_pkg::dcm_cmd_t cmd_o
);
    import dcm_pkg::*;
    initial begin
        valid_o = 1'b0;
        cmd_o = '0;
    end
    task automatic send(input logic [1:0] tgt, input logic rw,
        input logic [4:0] adr, input logic [11:0] dat);
        @(posedge clk_i);
        valid_o <= 1'b1;
        cmd_o <= '{tgt, rw, adr, dat};
        @(posedge clk_i);
        valid_o <= 1'b0;
        // idle lines never repeat the last command
        cmd_o <= dcm_cmd_t'(~cmd_o);
    endtask
endmodule
`default_nettype wire

//--- bench/tb_dac_control_and_monitor_select.sv
// self-checking bench for the control word and monitor select block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_dac_control_and_monitor_select;
    import dcm_pkg::*;
    logic clk = 1'b0, rst = 1'b1, vld, strobe = 1'b0, hot = 1'b0;
    dcm_cmd_t cmd;
    logic [11:0] rd_data, rexp, exp_q[$];
    logic rd_vld, pd_hz, ref_hi, boost, ref_en, amps, mon_en, mon_ext;
    logic [31:0] tog;
    logic [5:0] mon_sel;
    int err_total = 0, compares = 0;
    always #2.5 clk = ~clk;
    dcm_host host_u (.clk_i(clk), .valid_o(vld), .cmd_o(cmd));
    dcm_ctrl dut_u (.CLK_I(clk), .RST_I(rst), .CMD_VALID_I(vld), .CMD_I(cmd),
        .LOAD_OUTPUTS_STROBE_I(strobe), .OVER_TEMP_I(hot),
        .RD_DATA_O(rd_data), .RD_VALID_O(rd_vld), .PD_HIGHZ_O(pd_hz),
        .REF_LEVEL_HIGH_O(ref_hi), .AMP_BOOST_O(boost), .INT_REF_EN_O(ref_en),
        .AMPS_POWERED_O(amps), .TOGGLE_SEL_B_O(tog), .MON_SEL_O(mon_sel),
        .MONITOR_OUTPUT_EN_O(mon_en), .MON_EXT_O(mon_ext));
    always @(posedge clk) if (rd_vld === 1'b1) begin
        rexp = (exp_q.size() > 0) ? exp_q.pop_front() : ~rd_data;
        `CHK(rd_data, rexp)
    end
    task automatic print_verdict;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [11:0] d);
        host_u.send(2'h0, 1'b0, CMD_CTRL, d);
    endtask
    task automatic rd(input logic [11:0] e);
        exp_q.push_back(e);
        host_u.send(2'h0, 1'b1, CMD_CTRL, 12'h0000);
        repeat (2) @(posedge clk);
    endtask
    task automatic pup;
        host_u.send(2'h0, 1'b0, CMD_PUP, 12'h0000);
        settle();
    endtask
    initial begin
        #100000;
        err_total++;
        print_verdict();
    end
    initial begin
        logic [11:0] w;
        logic [5:0] sels[6] = '{6'h00, 6'h1F, 6'h20, 6'h23, 6'h24, 6'h3F};
        w = 12'($urandom(32'ha915));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        settle();
        `CHK({pd_hz, ref_hi, boost, ref_en, amps}, 5'b11000)
        `CHK({mon_sel, mon_en}, 7'h7E)
        rd(12'h0C00);
        $display("test reset done");
        repeat (4) begin
            w = 12'($urandom);
            wr(w);
            settle();
            `CHK({pd_hz, ref_hi, boost, ref_en}, w[11:8])
            rd(w);
            host_u.send(2'h1, 1'b0, CMD_CTRL, ~w);
            host_u.send(2'h0, 1'b1, CMD_MON, ~w);
            rd(w);
        end
        $display("test control done");
        foreach (sels[i]) for (int en = 0; en < 2; en++) begin
            wr({4'h0, en[0], 7'h00});
            host_u.send(2'h0, 1'b0, CMD_MON, {sels[i], 6'($urandom)});
            settle();
            `CHK({mon_sel, mon_ext}, {sels[i], sels[i][5:2] == 4'h8})
            `CHK(mon_en, en[0] && sels[i] != 6'h3F)
        end
        $display("test monitor done");
        wr(12'h0005);
        settle();
        for (int k = 0; k < 3; k++) begin
            @(posedge clk) strobe <= 1'b1;
            @(posedge clk) strobe <= 1'b0;
            settle();
            `CHK(tog, (k % 2 == 0) ? 32'h00FF_00FF : 32'h0000_0000)
        end
        wr(12'h0004);
        settle();
        `CHK(tog, 32'h00FF_0000)
        $display("test toggle done");
        wr(12'h0040);
        pup();
        `CHK(amps, 1'b1)
        @(posedge clk) hot <= 1'b1;
        settle();
        `CHK(amps, 1'b0)
        pup();
        `CHK(amps, 1'b0)
        @(posedge clk) hot <= 1'b0;
        pup();
        `CHK(amps, 1'b1)
        host_u.send(2'h0, 1'b0, CMD_PDN, 12'h0000);
        settle();
        `CHK(amps, 1'b0)
        pup();
        `CHK(amps, 1'b1)
        $display("test thermal done");
        print_verdict();
    end
endmodule
`default_nettype wire
